// File: rtl/gpic_pkg.sv
package gpic_pkg;

    // ************************************************************
    // Register addresses and reset values
    // ************************************************************
    localparam logic [7:0] GPIC_ADDR_SPI_SEL = 8'hA6;
    localparam logic [7:0] GPIC_ADDR_CORE_EN = 8'hA8;
    localparam logic [7:0] GPIC_ADDR_LVL_LO = 8'hA9;
    localparam logic [7:0] GPIC_ADDR_PERIPH_EN = 8'hB8;
    localparam logic [7:0] GPIC_ADDR_LVL_HI = 8'hB9;
    localparam logic [7:0] GPIC_ADDR_FLAGS = 8'hC0;

    localparam logic [7:0] GPIC_RST_SPI_SEL = 8'h01;
    localparam logic [7:0] GPIC_RST_CORE_EN = 8'h00;
    localparam logic [7:0] GPIC_RST_LVL = 8'h00;
    localparam logic [7:0] GPIC_RST_PERIPH_EN = 8'h00;
    localparam logic [7:0] GPIC_RST_FLAGS = 8'h00;

    // Writable bit masks; other bits read as zero
    localparam logic [7:0] GPIC_MASK_SPI_SEL = 8'h03;
    localparam logic [7:0] GPIC_MASK_CORE_EN = 8'hBF;
    localparam logic [7:0] GPIC_MASK_LVL = 8'h3F;
    localparam logic [7:0] GPIC_MASK_PERIPH_EN = 8'hBF;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int GPIC_BIT_GLOBAL_EN = 7;
    localparam int GPIC_BIT_SEL_MASTER = 1;
    localparam int GPIC_BIT_SEL_SLAVE = 0;
    localparam int GPIC_FLAG_T2_RELOAD = 7;
    localparam int GPIC_FLAG_T2_OVF = 6;
    localparam int GPIC_FLAG_WAKEUP = 5;
    localparam int GPIC_FLAG_USB = 4;
    localparam int GPIC_FLAG_USB_RESUME = 3;
    localparam int GPIC_FLAG_SPI = 2;
    localparam int GPIC_FLAG_RADIO = 1;
    localparam int GPIC_FLAG_RADIO_PORT = 0;
    localparam logic [7:0] GPIC_AUTOCLR_MASK = 8'h3E;

    // ************************************************************
    // Source table, ascending vector order
    // ************************************************************
    localparam int GPIC_NSRC = 12;
    localparam int GPIC_NGRP = 6;
    localparam int GPIC_SRC_T2 = 5;
    localparam int GPIC_SRC_RADIO_PORT = 6;
    localparam int GPIC_SRC_RADIO = 7;
    localparam int GPIC_SRC_SPI = 8;
    localparam int GPIC_SRC_USB_RESUME = 9;
    localparam int GPIC_SRC_USB = 10;
    localparam int GPIC_SRC_WAKEUP = 11;

    localparam logic [15:0] GPIC_VEC [GPIC_NSRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
    localparam logic [2:0] GPIC_GRP [GPIC_NSRC] = '{
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
        3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5};

    typedef logic [1:0] gpic_level_t;

endpackage

// File: rtl/gpic_edge.sv
`timescale 1ns/100ps
// One-cycle pulse on a rising edge, or on either edge when BOTH is set
module gpic_edge #(
    parameter bit BOTH = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic level_in,
    output logic pulse
);
    logic prev;

    // Previous level
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev <= 1'b0;
        end else begin
            prev <= level_in;
        end
    end

    assign pulse = BOTH ? (level_in ^ prev) : (level_in & ~prev);
endmodule

// File: rtl/gpic_core.sv
`timescale 1ns/100ps
module gpic_core import gpic_pkg::*; (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    input wire logic ext0_req,
    input wire logic timer0_req,
    input wire logic ext1_req,
    input wire logic timer1_req,
    input wire logic serial_rx_req,
    input wire logic serial_tx_req,
    input wire logic timer2_overflow,
    input wire logic timer2_reload_event,
    input wire logic radio_port_ready,
    input wire logic radio_event,
    input wire logic spi_master_done,
    input wire logic spi_slave_done,
    input wire logic usb_resume_event,
    input wire logic usb_event,
    input wire logic internal_wakeup_event,
    output logic irq_req,
    output logic [15:0] irq_vector,
    input wire logic irq_ack,
    input wire logic irq_return
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] spi_line_source_select;
    logic [7:0] core_irq_enable;
    logic [7:0] group_level_low_bits;
    logic [7:0] peripheral_irq_enable;
    logic [7:0] group_level_high_bits;
    logic [7:0] irq_request_flags;
    logic [3:0] in_service;
    logic [3:0] req_idx;
    gpic_level_t req_lvl;

    logic [7:0] next_flags;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [GPIC_NSRC-1:0] pend;
    logic [3:0] next_best_idx;
    gpic_level_t next_best_lvl;
    logic next_any;
    logic cur_active;
    gpic_level_t cur_lvl;
    logic take;
    logic ev_t2_ovf, ev_t2_rel, ev_port, ev_radio, ev_master, ev_slave;
    logic ev_resume, ev_usb, ev_wake, spi_line;

    // ************************************************************
    // Event edge detectors
    // ************************************************************
    gpic_edge #(.BOTH(1'b0)) u_t2_ovf (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(timer2_overflow), .pulse(ev_t2_ovf));
    gpic_edge #(.BOTH(1'b0)) u_t2_rel (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(timer2_reload_event), .pulse(ev_t2_rel));
    gpic_edge #(.BOTH(1'b0)) u_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(radio_port_ready), .pulse(ev_port));
    gpic_edge #(.BOTH(1'b1)) u_radio (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(radio_event), .pulse(ev_radio));
    gpic_edge #(.BOTH(1'b1)) u_master (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(spi_master_done), .pulse(ev_master));
    gpic_edge #(.BOTH(1'b1)) u_slave (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(spi_slave_done), .pulse(ev_slave));
    gpic_edge #(.BOTH(1'b0)) u_resume (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(usb_resume_event), .pulse(ev_resume));
    gpic_edge #(.BOTH(1'b0)) u_usb (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(usb_event), .pulse(ev_usb));
    gpic_edge #(.BOTH(1'b0)) u_wake (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .level_in(internal_wakeup_event), .pulse(ev_wake));

    // Shared SPI completion line, gated by the source select
    assign spi_line = (ev_master & spi_line_source_select[GPIC_BIT_SEL_MASTER]) |
                      (ev_slave & spi_line_source_select[GPIC_BIT_SEL_SLAVE]);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Software writes, reserved bits held at zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            spi_line_source_select <= GPIC_RST_SPI_SEL;
            core_irq_enable <= GPIC_RST_CORE_EN;
            group_level_low_bits <= GPIC_RST_LVL;
            peripheral_irq_enable <= GPIC_RST_PERIPH_EN;
            group_level_high_bits <= GPIC_RST_LVL;
        end else if (sfr_we) begin
            unique case (sfr_addr)
                GPIC_ADDR_SPI_SEL: spi_line_source_select <= sfr_wdata & GPIC_MASK_SPI_SEL;
                GPIC_ADDR_CORE_EN: core_irq_enable <= sfr_wdata & GPIC_MASK_CORE_EN;
                GPIC_ADDR_LVL_LO: group_level_low_bits <= sfr_wdata & GPIC_MASK_LVL;
                GPIC_ADDR_PERIPH_EN: peripheral_irq_enable <= sfr_wdata & GPIC_MASK_PERIPH_EN;
                GPIC_ADDR_LVL_HI: group_level_high_bits <= sfr_wdata & GPIC_MASK_LVL;
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Request flags
    // ************************************************************
    // Hardware sets from the event lines
    always_comb begin
        flag_set = 8'h00;
        flag_set[GPIC_FLAG_T2_RELOAD] = ev_t2_rel;
        flag_set[GPIC_FLAG_T2_OVF] = ev_t2_ovf;
        flag_set[GPIC_FLAG_WAKEUP] = ev_wake;
        flag_set[GPIC_FLAG_USB] = ev_usb;
        flag_set[GPIC_FLAG_USB_RESUME] = ev_resume;
        flag_set[GPIC_FLAG_SPI] = spi_line;
        flag_set[GPIC_FLAG_RADIO] = ev_radio;
        flag_set[GPIC_FLAG_RADIO_PORT] = ev_port;
    end

    // Auto clear on entry to service of the matching source, except the sticky T2 and radio port flags
    always_comb begin
        flag_clr = 8'h00;
        if (irq_ack && irq_req) begin
            unique case (req_idx)
                4'(GPIC_SRC_RADIO): flag_clr[GPIC_FLAG_RADIO] = 1'b1;
                4'(GPIC_SRC_SPI): flag_clr[GPIC_FLAG_SPI] = 1'b1;
                4'(GPIC_SRC_USB_RESUME): flag_clr[GPIC_FLAG_USB_RESUME] = 1'b1;
                4'(GPIC_SRC_USB): flag_clr[GPIC_FLAG_USB] = 1'b1;
                4'(GPIC_SRC_WAKEUP): flag_clr[GPIC_FLAG_WAKEUP] = 1'b1;
                default: begin
                end
            endcase
        end
        flag_clr = flag_clr & GPIC_AUTOCLR_MASK;
    end

    // Write, then auto clear, then hardware set wins
    always_comb begin
        next_flags = irq_request_flags;
        if (sfr_we && sfr_addr == GPIC_ADDR_FLAGS) begin
            next_flags = sfr_wdata;
        end
        next_flags = (next_flags & ~flag_clr) | flag_set;
    end

    // Flag register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_request_flags <= GPIC_RST_FLAGS;
        end else begin
            irq_request_flags <= next_flags;
        end
    end

    // ************************************************************
    // Pending sources and arbitration
    // ************************************************************
    // Enabled pending request per source, ascending vector order
    always_comb begin
        pend[0] = ext0_req & core_irq_enable[0];
        pend[1] = timer0_req & core_irq_enable[1];
        pend[2] = ext1_req & core_irq_enable[2];
        pend[3] = timer1_req & core_irq_enable[3];
        pend[4] = (serial_rx_req | serial_tx_req) & core_irq_enable[4];
        pend[GPIC_SRC_T2] = (irq_request_flags[GPIC_FLAG_T2_OVF] & core_irq_enable[5]) |
            (irq_request_flags[GPIC_FLAG_T2_RELOAD] & peripheral_irq_enable[7]);
        pend[GPIC_SRC_RADIO_PORT] = irq_request_flags[GPIC_FLAG_RADIO_PORT] &
            peripheral_irq_enable[0];
        pend[GPIC_SRC_RADIO] = irq_request_flags[GPIC_FLAG_RADIO] & peripheral_irq_enable[1];
        pend[GPIC_SRC_SPI] = irq_request_flags[GPIC_FLAG_SPI] & peripheral_irq_enable[2];
        pend[GPIC_SRC_USB_RESUME] = irq_request_flags[GPIC_FLAG_USB_RESUME] &
            peripheral_irq_enable[3];
        pend[GPIC_SRC_USB] = irq_request_flags[GPIC_FLAG_USB] & peripheral_irq_enable[4];
        pend[GPIC_SRC_WAKEUP] = irq_request_flags[GPIC_FLAG_WAKEUP] & peripheral_irq_enable[5];
    end

    // Highest level wins, ties to the lowest vector
    always_comb begin
        next_best_idx = 4'h0;
        next_best_lvl = 2'h0;
        next_any = 1'b0;
        for (int i = 0; i < GPIC_NSRC; i++) begin
            if (pend[i] && (!next_any ||
                {group_level_high_bits[GPIC_GRP[i]], group_level_low_bits[GPIC_GRP[i]]} >
                next_best_lvl)) begin
                next_best_idx = 4'(i);
                next_best_lvl = {group_level_high_bits[GPIC_GRP[i]],
                                 group_level_low_bits[GPIC_GRP[i]]};
                next_any = 1'b1;
            end
        end
    end

    // Highest level now in service
    always_comb begin
        cur_active = |in_service;
        cur_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (in_service[l]) begin
                cur_lvl = 2'(l);
            end
        end
    end

    assign take = next_any && core_irq_enable[GPIC_BIT_GLOBAL_EN] &&
                  (!cur_active || next_best_lvl > cur_lvl);

    // ************************************************************
    // Processor request and service tracking
    // ************************************************************
    // Request and vector presented to the processor; index and level kept for service tracking
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req <= 1'b0;
            irq_vector <= 16'h0000;
            req_idx <= 4'h0;
            req_lvl <= 2'h0;
        end else begin
            irq_req <= take && !(irq_ack && irq_req);
            irq_vector <= GPIC_VEC[next_best_idx];
            req_idx <= next_best_idx;
            req_lvl <= next_best_lvl;
        end
    end

    // One in-service bit per level; return retires the highest
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_service <= 4'h0;
        end else begin
            if (irq_return && cur_active) begin
                in_service[cur_lvl] <= 1'b0;
            end
            if (irq_ack && irq_req) begin
                in_service[req_lvl] <= 1'b1;
            end
        end
    end

    // Registered read data; unmapped reads return zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_re) begin
            unique case (sfr_addr)
                GPIC_ADDR_SPI_SEL: sfr_rdata <= spi_line_source_select;
                GPIC_ADDR_CORE_EN: sfr_rdata <= core_irq_enable;
                GPIC_ADDR_LVL_LO: sfr_rdata <= group_level_low_bits;
                GPIC_ADDR_PERIPH_EN: sfr_rdata <= peripheral_irq_enable;
                GPIC_ADDR_LVL_HI: sfr_rdata <= group_level_high_bits;
                GPIC_ADDR_FLAGS: sfr_rdata <= irq_request_flags;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_reset_values: assert property (@(posedge ref_clk)
        $fell(sys_rst) |->
        (spi_line_source_select == 8'h01 && peripheral_irq_enable == 8'h00 &&
         group_level_low_bits == 8'h00 && group_level_high_bits == 8'h00 &&
         irq_request_flags == 8'h00))
        else $error("register reset value wrong");
    a_global_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !core_irq_enable[GPIC_BIT_GLOBAL_EN] |=> !irq_req)
        else $error("request while globally disabled");
    a_spi_merge: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ev_master && spi_line_source_select[1]) || (ev_slave && spi_line_source_select[0])
        |=> irq_request_flags[GPIC_FLAG_SPI])
        else $error("shared spi flag not set");
    a_spi_blocked: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!irq_request_flags[GPIC_FLAG_SPI] && !sfr_we && !(ev_slave && spi_line_source_select[0])
         && !(ev_master && spi_line_source_select[1])) |=> !irq_request_flags[GPIC_FLAG_SPI])
        else $error("deselected spi source set flag");
    a_radio_autoclr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (irq_ack && irq_req && req_idx == 4'(GPIC_SRC_RADIO) && !ev_radio && !sfr_we)
        |=> !irq_request_flags[GPIC_FLAG_RADIO])
        else $error("radio flag not auto cleared");
    a_sticky_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !sfr_we |=> (($past(irq_request_flags) & ~irq_request_flags) & 8'hC1) == 8'h00)
        else $error("sticky flag cleared without write");
    a_preempt_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cur_active && next_best_lvl <= cur_lvl) |=> !irq_req)
        else $error("preempted by equal or lower level");
    a_vector_table: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_req && req_idx == 4'(GPIC_SRC_SPI) |-> irq_vector == 16'h0053)
        else $error("spi vector wrong");
    a_level_form: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_req |-> req_lvl == {group_level_high_bits[GPIC_GRP[req_idx]],
                                group_level_low_bits[GPIC_GRP[req_idx]]})
        else $error("level not formed from high and low bits");
    a_ack_service: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_ack && irq_req |=> in_service[$past(req_lvl)] && !irq_req)
        else $error("ack not recorded in service");

    c_spi_taken: cover property (@(posedge ref_clk) disable iff (sys_rst)
        irq_ack && irq_req && req_idx == 4'(GPIC_SRC_SPI));
    c_nested: cover property (@(posedge ref_clk) disable iff (sys_rst)
        in_service[3] && in_service[0]);
    c_set_and_clear: cover property (@(posedge ref_clk) disable iff (sys_rst)
        ev_radio && flag_clr[GPIC_FLAG_RADIO]);
endmodule

// File: testbench/gpic_cpu_model.sv
`timescale 1ns/100ps
// ************************************************************
// Processor core stand-in: enters service and returns from it
// ************************************************************
module gpic_cpu_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic irq_req,
    output logic irq_ack,
    output logic irq_return
);
    int wait_cnt;

    // Acknowledge once the offer has stood for ACK_DELAY cycles
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt <= 0;
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= irq_req && !irq_ack && (wait_cnt == ACK_DELAY);
            wait_cnt <= irq_req ? wait_cnt + 1 : 0;
        end
    end

    initial irq_return = 1'b0;

    // Return from the current service routine, one-cycle pulse
    task automatic service_return();
        @(posedge ref_clk);
        irq_return <= 1'b1;
        @(posedge ref_clk);
        irq_return <= 1'b0;
    endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb import gpic_pkg::*;;
    logic ref_clk;
    logic sys_rst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_we;
    logic sfr_re;
    logic [7:0] sfr_rdata;
    logic [5:0] core_req;
    logic [7:0] ev;
    logic spi_master;
    logic irq_req;
    logic [15:0] irq_vector;
    logic irq_ack;
    logic irq_return;
    int bad_count;
    int n_tests;

    // ************************************************************
    // Clock, design and processor stand-in
    // ************************************************************
    always #25 ref_clk = ~ref_clk;

    gpic_core i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
        .ext0_req(core_req[0]), .timer0_req(core_req[1]), .ext1_req(core_req[2]),
        .timer1_req(core_req[3]), .serial_rx_req(core_req[4]), .serial_tx_req(core_req[5]),
        .timer2_overflow(ev[6]), .timer2_reload_event(ev[7]), .radio_port_ready(ev[0]),
        .radio_event(ev[1]), .spi_master_done(spi_master), .spi_slave_done(ev[2]),
        .usb_resume_event(ev[3]), .usb_event(ev[4]), .internal_wakeup_event(ev[5]),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .irq_return(irq_return));

    gpic_cpu_model i_cpu (.ref_clk(ref_clk), .sys_rst(sys_rst), .irq_req(irq_req),
        .irq_ack(irq_ack), .irq_return(irq_return));

    // ************************************************************
    // Bus cycles, waits and comparisons
    // ************************************************************
    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_we <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_we <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_re <= 1'b1;
        sfr_addr <= a;
        @(posedge ref_clk);
        sfr_re <= 1'b0;
        #1;
        check({8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // Bounded wait for the request line to reach a level
    task automatic wait_req(input logic lvl);
        int k;
        k = 0;
        while (irq_req !== lvl && k < 60) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (irq_req !== lvl) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, irq_req, lvl);
            complete_run();
        end
    endtask

    // Offer seen, vector compared, then taken by the processor
    task automatic serve(input logic [15:0] v);
        wait_req(1'b1);
        check(irq_vector, v);
        wait_req(1'b0);
    endtask

    // No offer may appear for eight cycles
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(posedge ref_clk);
            #1;
            seen = seen | irq_req;
        end
        check({15'h0000, seen}, 16'h0000);
    endtask

    function automatic logic [15:0] vec_of(input int k);
        if (k >= 6) begin
            return 16'h002B;
        end
        return 16'h0043 + 16'(k) * 16'h0008;
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        {sfr_addr, sfr_wdata, sfr_we, sfr_re, core_req, ev, spi_master} = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Reset values, reserved bits and an unmapped address
        rd_chk(8'hA6, 8'h01);
        rd_chk(8'hA8, 8'h00);
        rd_chk(8'hA9, 8'h00);
        rd_chk(8'hB8, 8'h00);
        rd_chk(8'hB9, 8'h00);
        rd_chk(8'hC0, 8'h00);
        wr(8'hA6, 8'hFF);
        wr(8'hA9, 8'hFF);
        wr(8'hB8, 8'hFF);
        wr(8'hB9, 8'hFF);
        wr(8'h55, 8'hFF);
        rd_chk(8'hA6, 8'h03);
        rd_chk(8'hA9, 8'h3F);
        rd_chk(8'hB8, 8'hBF);
        rd_chk(8'hB9, 8'h3F);
        rd_chk(8'h55, 8'h00);
        wr(8'hA9, 8'h00);
        wr(8'hB9, 8'h00);
        wr(8'hA6, 8'h01);
        // Each flag source: masked by its own enable, then served
        for (int k = 0; k < 8; k++) begin
            wr(8'hA8, 8'h80);
            wr(8'hB8, 8'hBF & ~(8'h01 << k));
            ev[k] <= 1'b1;
            quiet();
            if (k == 6) begin
                wr(8'hA8, 8'hA0);
            end else begin
                wr(8'hB8, 8'hBF);
            end
            serve(vec_of(k));
            rd_chk(8'hC0, (8'h01 << k) & 8'hC1);
            wr(8'hC0, 8'h00);
            i_cpu.service_return();
        end
        // Shared SPI line follows the source select
        wr(8'hA8, 8'h00);
        spi_master <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(8'hC0, 8'h00);
        wr(8'hA6, 8'h02);
        spi_master <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_chk(8'hC0, 8'h04);
        quiet();
        wr(8'hA8, 8'h80);
        serve(16'h0053);
        i_cpu.service_return();
        // Levels, preemption and ties
        wr(8'hA8, 8'h00);
        wr(8'hA9, 8'h10);
        wr(8'hB9, 8'h20);
        wr(8'hC0, 8'h13);
        wr(8'hA8, 8'h80);
        serve(16'h0063);
        quiet();
        rd_chk(8'hC0, 8'h03);
        wr(8'hC0, 8'h23);
        serve(16'h006B);
        i_cpu.service_return();
        i_cpu.service_return();
        serve(16'h0043);
        rd_chk(8'hC0, 8'h03);
        wr(8'hC0, 8'h02);
        i_cpu.service_return();
        serve(16'h004B);
        i_cpu.service_return();
        // Core level sources
        wr(8'hA8, 8'hBF);
        for (int i = 0; i < 6; i++) begin
            core_req <= 6'h01 << i;
            serve((i < 5) ? 16'(i * 8 + 3) : 16'h0023);
            @(posedge ref_clk);
            core_req <= '0;
            i_cpu.service_return();
        end
        complete_run();
    end
endmodule
